// ---- design/tgs_params.svh ----
// constants for the thermal guard and status indicator block
`ifndef TGS_PARAMS_SVH
`define TGS_PARAMS_SVH
`define TGS_CLK_KHZ 200000
`define TGS_FILTER_MS 10
`define TGS_IND_MS 5000
`define TGS_RECHECK_MS 10000
`define TGS_NT_DELAY_MS 1
`define TGS_FAST_MS 125
`define TGS_SLOW_MS 1000
`define TGS_ADDR_CTRL 4'h0
`define TGS_ADDR_STATUS 4'h4
`define TGS_ADDR_LED 4'h8
`define TGS_CTRL_EXT 0
`define TGS_CTRL_RAIL 1
`define TGS_CTRL_CLR 2
`define TGS_CTRL_RST 32'h0000_0000
`define TGS_RESP_OKAY 2'b00
`define TGS_RESP_SLVERR 2'b10
`endif

// ---- design/tgs_pkg.sv ----
// types for the thermal guard and status indicator block
package tgs_pkg;
   typedef enum logic [1:0] {LD_ON, LD_LOCK, LD_CHECK_OK, LD_SUPPLY} tgs_load_e;
   typedef enum logic [1:0] {COL_OFF, COL_GREEN, COL_RED, COL_YELLOW} tgs_color_e;
   typedef enum logic [1:0] {MD_STEADY, MD_FAST, MD_SLOW, MD_PULSE} tgs_mode_e;
   typedef enum logic [1:0] {PH_PRECHARGE, PH_CONST_CURRENT, PH_DISCHARGE, PH_CONST_VOLTAGE}
      tgs_phase_e;
endpackage : tgs_pkg

// ---- design/tgs_guard.sv ----
// thermal guard, load and charge gating, indicator and rail control with axi4-lite registers
`timescale 1ns/100ps
`include "tgs_params.svh"
module tgs_guard
   import tgs_pkg::*;
#(
   parameter int unsigned FILTER_CYC = `TGS_FILTER_MS * `TGS_CLK_KHZ,
   parameter int unsigned IND_CYC = `TGS_IND_MS * `TGS_CLK_KHZ,
   parameter int unsigned RECHECK_CYC = `TGS_RECHECK_MS * `TGS_CLK_KHZ,
   parameter int unsigned NT_DELAY_CYC = `TGS_NT_DELAY_MS * `TGS_CLK_KHZ,
   parameter int unsigned FAST_CYC = `TGS_FAST_MS * `TGS_CLK_KHZ,
   parameter int unsigned SLOW_CYC = `TGS_SLOW_MS * `TGS_CLK_KHZ
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // user switch and thermistor comparators
   input wire logic user_switch_in_n,
   input wire logic temp_below_t1,
   input wire logic temp_below_t2,
   input wire logic temp_above_t3,
   input wire logic temp_above_t4,
   // cell and supply comparators
   input wire logic supply_detect,
   input wire logic cells_above_middle,
   input wire logic cell_below_min,
   input wire logic cell_at_max,
   input wire logic cell_below_short,
   input wire logic load_cutoff_reached,
   input wire logic overload_fault,
   // charger core status
   input wire logic [1:0] charge_phase,
   input wire logic charge_current_low,
   input wire logic charge_timeout,
   // controls and indicators
   output logic load_enable,
   output logic charge_enable,
   output logic current_reduce,
   output logic analog_supply_rail,
   output logic wake_pulse,
   output logic red_indicator,
   output logic green_indicator
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic reached(input logic [31:0] cnt, input int unsigned lim);
      reached = (cnt >= lim - 1);
   endfunction : reached

   logic sw_closed;
   logic sw_closed_q;
   logic sw_press;
   logic sw_release;
   logic [3:0] viol;
   logic [31:0] filt_cnt [4];
   logic [3:0] filt;
   logic any_viol;
   logic long_fault;
   logic short_warn;
   tgs_load_e load_st;
   logic lock_ind;
   logic ok_ind;
   logic [31:0] nt_cnt;
   logic supply_cut;
   logic [31:0] rc_cnt;
   logic temp_hold;
   logic charge_done;
   logic bat_err;
   logic tmo_err;
   logic ovl_err;
   logic charging;
   logic [31:0] ind_cnt;
   tgs_color_e ind_col;
   tgs_mode_e ind_md;
   logic [31:0] fast_cnt;
   logic [31:0] slow_cnt;
   logic fast_on;
   tgs_color_e col;
   tgs_mode_e md;
   logic lit;
   logic [31:0] ctrl;
   logic clr_pulse;

   assign sw_closed = ~user_switch_in_n;
   assign sw_press = sw_closed & ~sw_closed_q;
   assign sw_release = ~sw_closed & sw_closed_q;
   assign viol = {temp_above_t4, temp_above_t3, temp_below_t2, temp_below_t1};
   assign any_viol = |viol;
   assign long_fault = |filt;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sw_closed_q <= 1'b0;
      end else begin
         sw_closed_q <= sw_closed;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-threshold fault filter
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            filt_cnt[i] <= 32'h0000_0000;
         end
         filt <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!viol[i]) begin
               filt_cnt[i] <= 32'h0000_0000;
               filt[i] <= 1'b0;
            end else if (reached(filt_cnt[i], FILTER_CYC)) begin
               filt[i] <= 1'b1;
            end else begin
               filt_cnt[i] <= filt_cnt[i] + 32'h0000_0001;
            end
         end
      end
   end

   // a violation seen while working but never filtered is only warned about
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         short_warn <= 1'b0;
      end else if (sw_closed && long_fault) begin
         short_warn <= 1'b0;
      end else if (sw_closed && any_viol) begin
         short_warn <= 1'b1;
      end else if (sw_release) begin
         short_warn <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // load state: lock after long fault, recheck on next closure
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_st <= LD_ON;
      end else begin
         unique case (load_st)
            LD_ON: begin
               if (sw_closed && long_fault) begin
                  load_st <= LD_LOCK;
               end else if (supply_cut && sw_closed) begin
                  load_st <= LD_SUPPLY;
               end
            end
            LD_LOCK: begin
               if (sw_press && !any_viol && cells_above_middle) begin
                  load_st <= LD_CHECK_OK;
               end
            end
            LD_CHECK_OK: begin
               if (sw_release) begin
                  load_st <= LD_ON;
               end
            end
            LD_SUPPLY: begin
               if (!sw_closed) begin
                  load_st <= LD_ON;
               end
            end
         endcase
      end
   end

   assign lock_ind = (load_st == LD_ON) && sw_closed && long_fault;
   assign ok_ind = (load_st == LD_CHECK_OK) && sw_release;

   // load dropped a fixed delay after supply insertion
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nt_cnt <= 32'h0000_0000;
         supply_cut <= 1'b0;
      end else if (!supply_detect) begin
         nt_cnt <= 32'h0000_0000;
         supply_cut <= 1'b0;
      end else if (reached(nt_cnt, NT_DELAY_CYC)) begin
         supply_cut <= 1'b1;
      end else begin
         nt_cnt <= nt_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_enable <= 1'b0;
      end else begin
         load_enable <= (load_st == LD_ON) && !supply_cut && !filt[0] && !filt[3]
            && !(sw_closed && long_fault);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // recheck and wake timer, free running while supply present
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rc_cnt <= 32'h0000_0000;
         wake_pulse <= 1'b0;
      end else if (!supply_detect) begin
         rc_cnt <= 32'h0000_0000;
         wake_pulse <= 1'b0;
      end else if (reached(rc_cnt, RECHECK_CYC)) begin
         rc_cnt <= 32'h0000_0000;
         wake_pulse <= 1'b1;
      end else begin
         rc_cnt <= rc_cnt + 32'h0000_0001;
         wake_pulse <= 1'b0;
      end
   end

   assign charging = supply_detect && !sw_closed && !charge_done && !bat_err && !tmo_err;

   // charge hold after a temperature fault, released at a recheck or a switch press
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         temp_hold <= 1'b0;
      end else if (!supply_detect) begin
         temp_hold <= 1'b0;
      end else if (charging && long_fault) begin
         temp_hold <= 1'b1;
      end else if ((wake_pulse || sw_press) && !any_viol) begin
         temp_hold <= 1'b0;
      end
   end

   // charge completion; a wake with a low cell starts a new cycle
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         charge_done <= 1'b0;
      end else if (!supply_detect) begin
         charge_done <= 1'b0;
      end else if (charging && !temp_hold && charge_phase == PH_CONST_VOLTAGE
            && charge_current_low) begin
         charge_done <= 1'b1;
      end else if (wake_pulse && !cells_above_middle) begin
         charge_done <= 1'b0;
      end
   end

   // error latches: set wins over clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bat_err <= 1'b0;
         tmo_err <= 1'b0;
         ovl_err <= 1'b0;
      end else begin
         if ((cell_below_min && cell_at_max) || cell_below_short) begin
            bat_err <= 1'b1;
         end else if (clr_pulse || !supply_detect && sw_press) begin
            bat_err <= 1'b0;
         end
         if (charge_timeout) begin
            tmo_err <= 1'b1;
         end else if (clr_pulse || !supply_detect) begin
            tmo_err <= 1'b0;
         end
         if (overload_fault) begin
            ovl_err <= 1'b1;
         end else if (clr_pulse || sw_press) begin
            ovl_err <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         charge_enable <= 1'b0;
         current_reduce <= 1'b0;
      end else begin
         charge_enable <= charging && !temp_hold && !filt[0] && !filt[1]
            && !filt[2] && !filt[3];
         current_reduce <= charge_phase == PH_CONST_VOLTAGE && cell_at_max;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // analog rail; an external controller owns it when selected
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         analog_supply_rail <= 1'b0;
      end else if (ctrl[`TGS_CTRL_EXT]) begin
         analog_supply_rail <= ctrl[`TGS_CTRL_RAIL];
      end else begin
         analog_supply_rail <= sw_closed || (supply_detect && !charge_done)
            || wake_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timed indication, armed at fault or at release
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ind_cnt <= 32'h0000_0000;
         ind_col <= COL_OFF;
         ind_md <= MD_STEADY;
      end else if (lock_ind) begin
         ind_cnt <= IND_CYC;
         ind_col <= COL_YELLOW;
         ind_md <= MD_SLOW;
      end else if (ok_ind) begin
         ind_cnt <= IND_CYC;
         ind_col <= COL_GREEN;
         ind_md <= MD_STEADY;
      end else if (sw_release && load_st == LD_ON) begin
         ind_cnt <= IND_CYC;
         ind_md <= MD_STEADY;
         if (short_warn) begin
            ind_col <= COL_YELLOW;
         end else if (load_cutoff_reached) begin
            ind_col <= COL_RED;
         end else if (cells_above_middle) begin
            ind_col <= COL_GREEN;
         end else begin
            ind_col <= COL_YELLOW;
         end
      end else if (ind_cnt != 32'h0000_0000) begin
         ind_cnt <= ind_cnt - 32'h0000_0001;
      end
   end

   // flash time bases
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fast_cnt <= 32'h0000_0000;
         slow_cnt <= 32'h0000_0000;
         fast_on <= 1'b0;
      end else begin
         if (reached(fast_cnt, FAST_CYC)) begin
            fast_cnt <= 32'h0000_0000;
            fast_on <= ~fast_on;
         end else begin
            fast_cnt <= fast_cnt + 32'h0000_0001;
         end
         if (reached(slow_cnt, SLOW_CYC)) begin
            slow_cnt <= 32'h0000_0000;
         end else begin
            slow_cnt <= slow_cnt + 32'h0000_0001;
         end
      end
   end

   // display priority: timeout and battery errors, timed code, overload error, charge state
   always_comb begin
      col = COL_OFF;
      md = MD_STEADY;
      if (tmo_err) begin
         col = COL_RED;
         md = MD_FAST;
      end else if (bat_err) begin
         col = COL_RED;
         md = MD_SLOW;
      end else if (ind_cnt != 32'h0000_0000) begin
         col = ind_col;
         md = ind_md;
      end else if (ovl_err) begin
         col = COL_YELLOW;
         md = MD_FAST;
      end else if (charge_done) begin
         col = COL_GREEN;
      end else if (charging) begin
         col = COL_GREEN;
         md = MD_PULSE;
      end
   end

   // short pulse is one eighth of the slow period, long three quarters
   always_comb begin
      unique case (md)
         MD_STEADY: lit = 1'b1;
         MD_FAST: lit = fast_on;
         MD_SLOW: lit = slow_cnt < (SLOW_CYC / 2);
         MD_PULSE: lit = (charge_phase == PH_CONST_VOLTAGE) ?
            slow_cnt < (SLOW_CYC / 4 * 3) : slow_cnt < (SLOW_CYC / 8);
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         red_indicator <= 1'b0;
         green_indicator <= 1'b0;
      end else begin
         red_indicator <= !sw_closed && lit && col inside {COL_RED, COL_YELLOW};
         green_indicator <= !sw_closed && lit && col inside {COL_GREEN, COL_YELLOW};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data taken in either order
   logic aw_held;
   logic w_held;
   logic [3:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_q <= 4'h0;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TGS_RESP_OKAY;
         ctrl <= `TGS_CTRL_RST;
         clr_pulse <= 1'b0;
      end else begin
         clr_pulse <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `TGS_RESP_OKAY;
            if (aw_q == `TGS_ADDR_CTRL) begin
               if (ws_q[0]) begin
                  ctrl[1:0] <= w_q[1:0];
                  clr_pulse <= w_q[`TGS_CTRL_CLR];
               end
            end else if (aw_q != `TGS_ADDR_STATUS && aw_q != `TGS_ADDR_LED) begin
               s_axi_bresp <= `TGS_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TGS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `TGS_RESP_OKAY;
         unique case (s_axi_araddr)
            `TGS_ADDR_CTRL: s_axi_rdata <= {30'h0000_0000, ctrl[1:0]};
            `TGS_ADDR_STATUS: s_axi_rdata <= {16'h0000, 2'b00, load_st, filt,
               temp_hold, charge_done, bat_err, tmo_err,
               ovl_err, short_warn, supply_cut, sw_closed};
            `TGS_ADDR_LED: s_axi_rdata <= {24'h00_0000, 2'b00, md, col,
               red_indicator, green_indicator};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `TGS_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : tgs_guard

// ---- tb/tgs_guard_props.sv ----
// checker for the thermal guard outputs
`timescale 1ns/100ps
module tgs_guard_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // switch, thermistor and supply inputs
   input wire logic user_switch_in_n,
   input wire logic temp_below_t1,
   input wire logic temp_below_t2,
   input wire logic temp_above_t3,
   input wire logic temp_above_t4,
   input wire logic supply_detect,
   // register bus handshakes
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // controls and indicators
   input wire logic load_enable,
   input wire logic charge_enable,
   input wire logic wake_pulse,
   input wire logic red_indicator,
   input wire logic green_indicator
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // temperature repeat counts follow the shortened filter of eight cycles
   property p_ind_off;
      !user_switch_in_n |=> !red_indicator && !green_indicator;
   endproperty
   a_ind_off: assert property (p_ind_off) else $error("indicator lit while switch on");
   property p_t1;
      temp_below_t1 [*8] |-> ##[1:4] !load_enable && !charge_enable;
   endproperty
   a_t1: assert property (p_t1) else $error("cold fault kept load or charge on");
   property p_t2;
      temp_below_t2 [*8] |-> ##[1:4] !charge_enable;
   endproperty
   a_t2: assert property (p_t2) else $error("cool fault kept charge on");
   property p_t3;
      temp_above_t3 [*8] |-> ##[1:4] !charge_enable;
   endproperty
   a_t3: assert property (p_t3) else $error("warm fault kept charge on");
   property p_t4;
      temp_above_t4 [*8] |-> ##[1:4] !load_enable && !charge_enable;
   endproperty
   a_t4: assert property (p_t4) else $error("hot fault kept load or charge on");
   property p_supply;
      supply_detect [*6] |-> ##[0:3] !load_enable;
   endproperty
   a_supply: assert property (p_supply) else $error("load kept on with supply");
   property p_wake;
      wake_pulse |=> !wake_pulse;
   endproperty
   a_wake: assert property (p_wake) else $error("wake pulse longer than one cycle");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write response not retired");
   c_charge: cover property (supply_detect && charge_enable);
   c_yellow: cover property (red_indicator && green_indicator);
   c_wake: cover property (wake_pulse);
endmodule : tgs_guard_props
bind tgs_guard tgs_guard_props u_props (.*);

// ---- tb/tgs_far_model.sv ----
// switch and thermistor comparators seen from the pack side
`timescale 1ns/100ps
module tgs_far_model (
   // commands from the bench
   input wire logic press,
   input wire logic [2:0] zone,
   // levels into the block
   output logic user_switch_in_n,
   output logic temp_below_t1,
   output logic temp_below_t2,
   output logic temp_above_t3,
   output logic temp_above_t4
);
   // released switch reads high through its pull-up
   assign user_switch_in_n = !press;
   // zone 1 coldest .. 4 hottest; outer thresholds imply the inner ones
   assign temp_below_t1 = (zone == 3'd1);
   assign temp_below_t2 = (zone == 3'd1) || (zone == 3'd2);
   assign temp_above_t3 = (zone == 3'd3) || (zone == 3'd4);
   assign temp_above_t4 = (zone == 3'd4);
endmodule : tgs_far_model

// ---- tb/tgs_guard_bench.sv ----
// self-checking bench for the thermal guard block
`timescale 1ns/100ps
`include "tgs_params.svh"
module tgs_guard_bench;
   import tgs_pkg::*;
   logic core_clk = 0, sys_rst = 1, press = 0;
   logic [2:0] zone = 3'd0;
   logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
   logic [31:0] wdata = 0, rd;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic supply = 0, mid = 1, cmin = 0, cmax = 0, cshort = 0, cut = 0, ovl = 0;
   logic [1:0] phase = 2'd0, rsp;
   logic ilow = 0, tmo = 0;
   logic awready, wready, bvalid, arready, rvalid, sw_n, t1, t2, t3, t4;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic load_enable, charge_enable, rail, wake, red, green, creduce;
   int n_mismatch = 0, checks_done = 0, rc, gc, rises;
   always #2.5 core_clk = ~core_clk;
   tgs_far_model far (.press(press), .zone(zone), .user_switch_in_n(sw_n),
      .temp_below_t1(t1), .temp_below_t2(t2), .temp_above_t3(t3), .temp_above_t4(t4));
   tgs_guard #(.FILTER_CYC(8), .IND_CYC(50), .RECHECK_CYC(40), .NT_DELAY_CYC(4),
      .FAST_CYC(4), .SLOW_CYC(16)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .user_switch_in_n(sw_n), .temp_below_t1(t1), .temp_below_t2(t2),
      .temp_above_t3(t3), .temp_above_t4(t4), .supply_detect(supply),
      .cells_above_middle(mid), .cell_below_min(cmin), .cell_at_max(cmax),
      .cell_below_short(cshort), .load_cutoff_reached(cut), .overload_fault(ovl),
      .charge_phase(phase), .charge_current_low(ilow), .charge_timeout(tmo),
      .load_enable(load_enable), .charge_enable(charge_enable), .current_reduce(creduce),
      .analog_supply_rail(rail), .wake_pulse(wake), .red_indicator(red),
      .green_indicator(green));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw;
      ta = 0;
      tw = 0;
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(ta && tw)) begin
         @(posedge core_clk);
         if (!ta && awready) begin ta = 1; awvalid <= 0; end
         if (!tw && wready) begin tw = 1; wvalid <= 0; end
      end
      do @(posedge core_clk); while (bvalid !== 1'b1);
      chk(bresp, er);
      bready <= 0;
      // one idle edge so a following write never re-raises bready in this step
      cyc(1);
   endtask : axw
   task automatic axr(input logic [3:0] a, input logic [1:0] er);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rd = rdata;
      chk(rresp, er);
      rready <= 0;
   endtask : axr
   // counts lit cycles and red rising edges over n cycles
   task automatic watch(input int n);
      logic pr;
      rc = 0; gc = 0; rises = 0; pr = red;
      repeat (n) begin
         @(posedge core_clk);
         rc += red; gc += green; rises += (red && !pr); pr = red;
      end
   endtask : watch
   // press and release with cells healthy: green after release, load back
   task automatic recheck();
      press <= 1; cyc(6);
      chk({red, green}, 0);
      chk(rail, 1);
      press <= 0; cyc(4);
      chk({red, green}, 2'b01);
      cyc(3); chk(load_enable, 1);
   endtask : recheck
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      axr(`TGS_ADDR_CTRL, `TGS_RESP_OKAY); chk(rd, `TGS_CTRL_RST);
      axw(`TGS_ADDR_CTRL, 32'h0000_0007, `TGS_RESP_OKAY);
      axr(`TGS_ADDR_CTRL, `TGS_RESP_OKAY); chk(rd, 32'h0000_0003);
      chk(rail, 1);
      axw(`TGS_ADDR_CTRL, 32'h0000_0000, `TGS_RESP_OKAY);
      wstrb <= 4'h0; axw(`TGS_ADDR_CTRL, 32'h0000_0003, `TGS_RESP_OKAY);
      wstrb <= 4'hf; axr(`TGS_ADDR_CTRL, `TGS_RESP_OKAY); chk(rd, 0);
      chk(rail, 0);
      axw(`TGS_ADDR_STATUS, 32'hffff_ffff, `TGS_RESP_OKAY);
      axr(`TGS_ADDR_STATUS, `TGS_RESP_OKAY); chk(rd[0], 0);
      axw(4'hc, 32'h0000_0001, `TGS_RESP_SLVERR);
      axr(4'hc, `TGS_RESP_SLVERR); chk(rd, 0);
   endtask : t_regs
   task automatic t_temp();
      for (int z = 1; z <= 4; z++) begin
         zone <= 3'(z); cyc(14);
         chk(load_enable, (z == 2 || z == 3));
         zone <= 3'd0; cyc(3);
         recheck();
      end
      press <= 1; cyc(2); zone <= 3'd4; cyc(3); zone <= 3'd0; cyc(3);
      press <= 0; cyc(4);
      chk({red, green}, 2'b11);
      chk(load_enable, 1);
      cyc(60); press <= 1; zone <= 3'd4; cyc(14);
      chk(load_enable, 0);
      zone <= 3'd0; press <= 0; cyc(3); watch(32);
      chk(rc == gc && rises >= 1 && rises <= 2, 1);
      chk(rc > 0, 1);
      cyc(30); recheck();
   endtask : t_temp
   task automatic t_charge();
      int g;
      press <= 1; supply <= 1; cyc(10);
      chk(load_enable, 0);
      chk(charge_enable, 0);
      press <= 0; cyc(6);
      chk(charge_enable, 1);
      chk(rail, 1);
      // release from LD_SUPPLY arms no timed indication; settle before judging the pulse widths
      cyc(30); watch(32); chk(rc, 0);
      chk(gc, 4);
      g = gc; phase <= 2'd3; cyc(2); watch(32);
      chk(gc, 24);
      chk(g < gc, 1);
      chk(creduce, 0);
      cmax <= 1; cyc(2); chk(creduce, 1);
      cmax <= 0;
      zone <= 3'd3; cyc(14); chk(charge_enable, 0);
      zone <= 3'd0; rc = 0;
      while (charge_enable !== 1'b1 && rc < 100) begin cyc(1); rc++; end
      chk(charge_enable, 1);
      ilow <= 1; cyc(8); chk(charge_enable, 0);
      watch(100); chk(gc, 100);
      rc = 0; repeat (100) begin cyc(1); rc += wake; end
      chk(rc >= 2, 1);
      supply <= 0; ilow <= 0; phase <= 2'd0; cyc(5);
      chk(green, 0);
      chk(rail, 0);
   endtask : t_charge
   task automatic t_codes();
      for (int i = 0; i < 3; i++) begin
         recheck(); cyc(60);
         // timeout only latches while the charge supply is present
         supply <= (i == 1);
         ovl <= (i == 0); tmo <= (i == 1); cmin <= (i == 2); cmax <= (i == 2); cyc(3);
         ovl <= 0; tmo <= 0; cmin <= 0; cmax <= 0; cyc(4); watch(32);
         chk(gc, (i == 0) ? rc : 0);
         chk(rises >= 3, i < 2);
         axw(`TGS_ADDR_CTRL, 32'h0000_0004, `TGS_RESP_OKAY);
         supply <= 0; cyc(1);
      end
      cshort <= 1; cyc(3); cshort <= 0; cyc(4); watch(32);
      chk(rc > 0 && gc == 0, 1);
      axw(`TGS_ADDR_CTRL, 32'h0000_0004, `TGS_RESP_OKAY);
      // gauge after release: low cells yellow, cut-off reached red
      mid <= 0; press <= 1; cyc(4); press <= 0; cyc(4);
      chk({red, green}, 2'b11);
      cut <= 1; press <= 1; cyc(4); press <= 0; cyc(4);
      chk({red, green}, 2'b10);
      mid <= 1; cut <= 0;
   endtask : t_codes
   task automatic test_done();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   initial begin
      cyc(4); chk(load_enable, 0);
      cyc(4); sys_rst <= 0; cyc(3);
      chk(load_enable, 1);
      t_regs();
      t_temp();
      t_charge();
      t_codes();
      test_done();
   end
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
endmodule : tgs_guard_bench
